/* File: verilog/sgm_pkg.sv */
/*
 * constants for the safeguard and emergency stop monitor.
 * assumes a single 125 MHz system clock; no bus, all bits are ports.
 */
package sgm_pkg;
    // clock rate and documented discrepancy time
    localparam int unsigned SGM_CLK_HZ = 125000000;
    localparam int unsigned SGM_DISC_MS = 2000;
    // cycles for two seconds, a least time so rounded up
    localparam longint unsigned SGM_DISC_CYC_L =
        (longint'(SGM_DISC_MS) * longint'(SGM_CLK_HZ) + 64'd999) / 64'd1000;
    localparam int unsigned SGM_DISC_CYC = int'(SGM_DISC_CYC_L);
    localparam int SGM_CNT_W = 28;
    // supervisor states
    typedef enum logic [2:0] {
        SGM_ST_IDLE,
        SGM_ST_RUN,
        SGM_ST_DECEL,
        SGM_ST_SAFE,
        SGM_ST_ESTOP
    } sgm_state_type;
endpackage

/* File: verilog/sgm_sync.sv */
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the pin is asynchronous to clk_sys; reset value is a parameter.
 */
`timescale 1ns/1ps
module sgm_sync import sgm_pkg::*; #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // pin and synchronised level
    input wire logic pin,
    output logic level
);
    logic meta; // first stage, read only by level
    logic next_meta;
    logic next_level;

    // next values
    always_comb begin
        next_meta = pin;
        next_level = meta;
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta <= RST_VAL;
            level <= RST_VAL;
        end else begin
            meta <= next_meta;
            level <= next_level;
        end
    end
endmodule

/* File: verilog/sgm_disc.sv */
/*
 * discrepancy timer for a redundant channel pair.
 * assumes both channels are already synchronised to clk_sys.
 */
`timescale 1ns/1ps
module sgm_disc import sgm_pkg::*; #(
    parameter int unsigned LIMIT = SGM_DISC_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // channel pair
    input wire logic ch_a,
    input wire logic ch_b,
    // explicit error reset
    input wire logic err_clr,
    // latched critical error
    output logic err
);
    logic [SGM_CNT_W-1:0] cnt; // cycles of continuous disagreement
    logic [SGM_CNT_W-1:0] next_cnt;
    logic next_err;
    localparam logic [SGM_CNT_W-1:0] LIM = SGM_CNT_W'(LIMIT);

    // count while disagreeing, restart on agreement
    always_comb begin
        next_cnt = cnt;
        next_err = err;
        if (ch_a != ch_b) begin
            if (cnt < LIM) begin
                next_cnt = cnt + 1'b1;
            end
        end else begin
            next_cnt = '0;
        end
        if (err_clr) begin
            next_err = 1'b0;
        end
        // set wins over clear
        if ((ch_a != ch_b) && (cnt >= LIM - 1'b1)) begin
            next_err = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            err <= 1'b0;
        end else begin
            cnt <= next_cnt;
            err <= next_err;
        end
    end

    // error rises only right after a cycle of disagreement
    err_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(err) |-> $past(ch_a != ch_b))
        else $error("error raised without disagreement");
    cnt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ch_a == ch_b) |=> (cnt == '0))
        else $error("timer not restarted on agreement");
    err_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        err && !err_clr |=> err)
        else $error("critical error dropped without reset");
endmodule

/* File: verilog/sgm_monitor.sv */
/*
 * safeguard and emergency stop supervisor: pin synchronisers, two
 * discrepancy timers, latches and the stop sequence.
 * assumes switch contacts arrive as asynchronous levels where 1 means
 * closed; an unconnected input reads 0, the unsafe value.
 */
`timescale 1ns/1ps
module sgm_monitor import sgm_pkg::*; #(
    parameter int unsigned DISC_CYC = SGM_DISC_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // safety door channels, 1 = door closed
    input wire logic door_ch1,
    input wire logic door_ch2,
    // emergency stop contacts, 1 = contact closed
    input wire logic estop_ch1,
    input wire logic estop_ch2,
    // latch release input, 1 = closed
    input wire logic latch_rel,
    // mode selector and enabling switch
    input wire logic jog_mode,
    input wire logic enable_sw,
    // controller side handshakes
    input wire logic start_req,
    input wire logic motion_active,
    input wire logic decel_done,
    input wire logic err_clr,
    // status and power outputs
    output logic halt,
    output logic paused,
    output logic motor_power,
    output logic high_power,
    output logic low_power,
    output logic op_prohibit,
    output logic dyn_brake,
    output logic door_latched,
    output logic jog_latched,
    output logic door_error,
    output logic estop_error
);
    // synchronised levels
    logic door1_s, door2_s, estop1_s, estop2_s, rel_s, jog_s, en_s;

    // door channel 1, resets to open so nothing is trusted early
    sgm_sync #(.RST_VAL(1'b0)) u_sync_d1 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(door_ch1),
        .level(door1_s)
    );
    // door channel 2
    sgm_sync #(.RST_VAL(1'b0)) u_sync_d2 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(door_ch2),
        .level(door2_s)
    );
    // stop contact 1
    sgm_sync #(.RST_VAL(1'b0)) u_sync_e1 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(estop_ch1),
        .level(estop1_s)
    );
    // stop contact 2
    sgm_sync #(.RST_VAL(1'b0)) u_sync_e2 (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(estop_ch2),
        .level(estop2_s)
    );
    // latch release, open keeps the records
    sgm_sync #(.RST_VAL(1'b0)) u_sync_rl (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(latch_rel),
        .level(rel_s)
    );
    // mode selector
    sgm_sync #(.RST_VAL(1'b0)) u_sync_jg (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(jog_mode),
        .level(jog_s)
    );
    // enabling switch
    sgm_sync #(.RST_VAL(1'b0)) u_sync_en (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(enable_sw),
        .level(en_s)
    );

    // discrepancy timers, one per redundant pair
    sgm_disc #(.LIMIT(DISC_CYC)) u_disc_door (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ch_a(door1_s),
        .ch_b(door2_s),
        .err_clr(err_clr),
        .err(door_error)
    );
    sgm_disc #(.LIMIT(DISC_CYC)) u_disc_estop (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ch_a(estop1_s),
        .ch_b(estop2_s),
        .err_clr(err_clr),
        .err(estop_error)
    );

    // a redundant pair counts as open unless both contacts read closed
    function automatic logic pair_open(input logic ch_a, input logic ch_b);
        return !(ch_a && ch_b);
    endfunction

    // derived conditions
    logic door_open; // either channel open counts as open
    logic estop_hit; // either contact open is a stop request
    logic crit_err;
    logic jog_override; // jog mode with enabling switch held
    assign door_open = pair_open(door1_s, door2_s);
    assign estop_hit = pair_open(estop1_s, estop2_s);
    assign crit_err = door_error || estop_error;
    assign jog_override = jog_s && en_s;

    // latched records
    logic next_door_latched, next_jog_latched;

    // set wins over release so a fresh cause is never lost
    always_comb begin
        next_door_latched = door_latched;
        next_jog_latched = jog_latched;
        if (rel_s) begin
            next_door_latched = 1'b0;
            next_jog_latched = 1'b0;
        end
        if (door_open) begin
            next_door_latched = 1'b1;
        end
        if (jog_s) begin
            next_jog_latched = 1'b1;
        end
    end

    // reset latches the door as open: nothing is trusted before release
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            door_latched <= 1'b1;
            jog_latched <= 1'b0;
        end else begin
            door_latched <= next_door_latched;
            jog_latched <= next_jog_latched;
        end
    end

    // supervisor state
    sgm_state_type state, next_state;
    logic start_ok; // all conditions for a deliberate start

    // operation allowed with door closed and latch released, or by jog override
    assign start_ok = !estop_hit && !crit_err &&
        ((!door_open && !door_latched && !jog_latched) || jog_override);

    // next state
    always_comb begin
        next_state = state;
        case (state)
            SGM_ST_IDLE: begin
                // only an explicit start request leaves idle
                if (start_req && start_ok) begin
                    next_state = SGM_ST_RUN;
                end
            end
            SGM_ST_RUN: begin
                if (estop_hit || crit_err) begin
                    next_state = SGM_ST_ESTOP;
                end else if (door_open && !jog_override) begin
                    // controlled stop first while moving, power stays on; straight to safe when not moving
                    next_state = motion_active ? SGM_ST_DECEL : SGM_ST_SAFE;
                end
            end
            SGM_ST_DECEL: begin
                if (estop_hit || crit_err) begin
                    next_state = SGM_ST_ESTOP;
                end else if (decel_done) begin
                    next_state = SGM_ST_SAFE;
                end
            end
            SGM_ST_SAFE: begin
                if (estop_hit || crit_err) begin
                    next_state = SGM_ST_ESTOP;
                end else if (!door_open || jog_override) begin
                    // closing the door alone does not restart motion
                    next_state = SGM_ST_IDLE;
                end
            end
            SGM_ST_ESTOP: begin
                if (!estop_hit && !crit_err) begin
                    next_state = SGM_ST_IDLE;
                end
            end
            default: begin
                next_state = SGM_ST_ESTOP;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= SGM_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // outputs registered from next values so they change on the same edge as the state
    logic next_halt, next_paused, next_power, next_high, next_low;
    logic next_prohibit, next_brake;

    always_comb begin
        next_halt = (next_state != SGM_ST_RUN);
        next_paused = (next_state == SGM_ST_DECEL) || (next_state == SGM_ST_SAFE);
        // power held during controlled deceleration only
        next_power = (next_state == SGM_ST_RUN) || (next_state == SGM_ST_DECEL);
        // high power only with door really closed
        next_high = (next_state == SGM_ST_RUN) && !door_open;
        next_low = (next_state == SGM_ST_RUN) && door_open;
        // door open without jog override keeps prohibit even if jog latch is cleared
        next_prohibit = (door_open && !jog_override) || estop_hit || crit_err;
        next_brake = (next_state == SGM_ST_ESTOP);
    end

    // output registers, safe values out of reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            halt <= 1'b1;
            paused <= 1'b0;
            motor_power <= 1'b0;
            high_power <= 1'b0;
            low_power <= 1'b0;
            op_prohibit <= 1'b1;
            dyn_brake <= 1'b0;
        end else begin
            halt <= next_halt;
            paused <= next_paused;
            motor_power <= next_power;
            high_power <= next_high;
            low_power <= next_low;
            op_prohibit <= next_prohibit;
            dyn_brake <= next_brake;
        end
    end

    // stop sequence built from named steps
    sequence door_open_moving_s;
        state == SGM_ST_RUN && door_open && !jog_override && motion_active
            && !estop_hit && !crit_err;
    endsequence
    sequence paused_powered_s;
        paused && motor_power;
    endsequence

    door_decel_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        door_open_moving_s |=> paused_powered_s ##0 halt)
        else $error("door opening did not start a controlled stop");
    decel_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == SGM_ST_DECEL && decel_done && !estop_hit && !crit_err)
            |=> (state == SGM_ST_SAFE) ##0 !motor_power)
        else $error("motors not off after deceleration");
    estop_cut_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (estop_hit && state != SGM_ST_IDLE) |=> !motor_power && dyn_brake)
        else $error("emergency stop did not cut power");
    no_autostart_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state != SGM_ST_RUN && !start_req) |=> (state != SGM_ST_RUN))
        else $error("restart without start request");
    open_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == SGM_ST_IDLE && door_open && !jog_override) |=> state != SGM_ST_RUN)
        else $error("run entered with door open");
    high_closed_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        high_power |-> $past(!door_open) && motor_power)
        else $error("high power with door open");
    latch_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (door_latched && !rel_s) |=> door_latched)
        else $error("door latch lost while release open");
    latch_set_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (door_open || jog_s) |=> (door_latched || !$past(door_open))
            && (jog_latched || !$past(jog_s)))
        else $error("latched record not set");
    prohibit_door_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (door_open && !jog_override) |=> op_prohibit)
        else $error("door open without prohibit");
    // release, refusal and low power checks
    jog_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (jog_latched && !rel_s) |=> jog_latched)
        else $error("jog latch lost while release open");
    release_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (rel_s && !door_open && !jog_s) |=> !door_latched && !jog_latched)
        else $error("latches not cleared by release");
    estop_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        estop_hit |=> (state != SGM_ST_RUN))
        else $error("run entered with stop contacts open");
    jog_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        low_power |-> motor_power && !high_power && !halt)
        else $error("low power run without motor power");
endmodule

/* File: bench/sgm_switches.sv */
/*
 * model of the external switches: door interlock, stop contacts,
 * latch release, mode selector and enabling switch.
 * assumes the bench calls its tasks; pins change at falling edges only.
 */
`timescale 1ns/1ps
module sgm_switches (
    // clock used only to time pin changes
    input wire logic clk_sys,
    // door and stop contacts, 1 = closed
    output logic door_ch1,
    output logic door_ch2,
    output logic estop_ch1,
    output logic estop_ch2,
    // latch release and mode pins
    output logic latch_rel,
    output logic jog_mode,
    output logic enable_sw
);
    // nothing attached at power-up: every contact reads open
    initial begin
        door_ch1 = 1'b0;
        door_ch2 = 1'b0;
        estop_ch1 = 1'b0;
        estop_ch2 = 1'b0;
        latch_rel = 1'b0;
        jog_mode = 1'b0;
        enable_sw = 1'b0;
    end
    // steady contact levels, no test pulses on the door pins
    task automatic door(input logic a, input logic b);
        @(negedge clk_sys);
        door_ch1 = a;
        door_ch2 = b;
    endtask
    // two normally closed contacts, open means stop
    task automatic estop(input logic a, input logic b);
        @(negedge clk_sys);
        estop_ch1 = a;
        estop_ch2 = b;
    endtask
    // selector and enabling switch
    task automatic mode(input logic j, input logic e);
        @(negedge clk_sys);
        jog_mode = j;
        enable_sw = e;
    endtask
    // caller closes door or leaves jog first
    task automatic release_pulse();
        @(negedge clk_sys);
        latch_rel = 1'b1;
        repeat (4) @(negedge clk_sys);
        latch_rel = 1'b0;
    endtask
endmodule

/* File: bench/tb_sgm_monitor.sv */
/*
 * self-checking bench for the safeguard and stop supervisor.
 * assumes the switch model drives the pins; short discrepancy time.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_sgm_monitor import sgm_pkg::*;;
    localparam int unsigned DISC = 20; // shortened two-second window
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic door_ch1, door_ch2, estop_ch1, estop_ch2, latch_rel, jog_mode, enable_sw;
    logic start_req = 1'b0;
    logic motion_active = 1'b0;
    logic decel_done = 1'b0;
    logic err_clr = 1'b0;
    logic halt, paused, motor_power, high_power, low_power, op_prohibit;
    logic dyn_brake, door_latched, jog_latched, door_error, estop_error;
    int bad_count = 0;
    int n_tests = 0;
    // 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    sgm_switches i_sgm_switches (.clk_sys(clk_sys), .door_ch1(door_ch1),
        .door_ch2(door_ch2), .estop_ch1(estop_ch1), .estop_ch2(estop_ch2),
        .latch_rel(latch_rel), .jog_mode(jog_mode), .enable_sw(enable_sw));
    sgm_monitor #(.DISC_CYC(DISC)) i_sgm_monitor (.clk_sys(clk_sys), .rst_b(rst_b),
        .door_ch1(door_ch1), .door_ch2(door_ch2), .estop_ch1(estop_ch1),
        .estop_ch2(estop_ch2), .latch_rel(latch_rel), .jog_mode(jog_mode),
        .enable_sw(enable_sw), .start_req(start_req), .motion_active(motion_active),
        .decel_done(decel_done), .err_clr(err_clr), .halt(halt), .paused(paused),
        .motor_power(motor_power), .high_power(high_power), .low_power(low_power),
        .op_prohibit(op_prohibit), .dyn_brake(dyn_brake), .door_latched(door_latched),
        .jog_latched(jog_latched), .door_error(door_error), .estop_error(estop_error));
    // falling-edge waits keep drives away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one-cycle restart request, then time for the answer to land
    task automatic start();
        start_req = 1'b1;
        tick(1);
        start_req = 1'b0;
        tick(3);
    endtask
    // drive one channel pair: 0 = door, 1 = stop
    task automatic pair(input int sel, input logic a, input logic b);
        if (sel == 0) i_sgm_switches.door(a, b);
        else i_sgm_switches.estop(a, b);
    endtask
    // short mismatch must not trip, long one must latch until cleared
    task automatic disc(input int sel);
        pair(sel, 1'b0, 1'b1);
        tick(DISC - 5);
        pair(sel, 1'b1, 1'b1);
        tick(4);
        `CHK({door_error, estop_error}, 2'h0)
        pair(sel, 1'b0, 1'b1);
        tick(DISC + 10);
        pair(sel, 1'b1, 1'b1);
        tick(4);
        `CHK(sel ? estop_error : door_error, 1'b1)
        err_clr = 1'b1;
        tick(1);
        err_clr = 1'b0;
        tick(3);
        `CHK({door_error, estop_error}, 2'h0)
    endtask
    // verdict and end of run
    task automatic results();
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        results();
    end
    // main sequence
    initial begin
        tick(8);
        `CHK({halt, op_prohibit, door_latched, motor_power}, 4'hE)
        rst_b = 1'b1;
        tick(4);
        start(); // nothing attached: inputs read open
        `CHK({halt, motor_power}, 2'h2)
        i_sgm_switches.door(1'b1, 1'b1);
        i_sgm_switches.estop(1'b1, 1'b1);
        tick(4);
        i_sgm_switches.release_pulse();
        tick(4);
        `CHK(door_latched, 1'b0)
        start();
        `CHK({halt, motor_power, high_power, op_prohibit}, 4'h6)
        // door opens in motion: controlled stop, power kept until decel done
        motion_active = 1'b1;
        i_sgm_switches.door(1'b0, 1'b0);
        tick(4);
        `CHK({paused, halt, high_power, op_prohibit}, 4'hD)
        `CHK({door_latched, motor_power}, 2'h3)
        decel_done = 1'b1;
        tick(2);
        decel_done = 1'b0;
        motion_active = 1'b0;
        `CHK(motor_power, 1'b0)
        i_sgm_switches.door(1'b1, 1'b1);
        tick(4);
        `CHK(halt, 1'b1)
        start(); // door latch still set
        `CHK(halt, 1'b1)
        i_sgm_switches.release_pulse();
        tick(4);
        start();
        `CHK(halt, 1'b0)
        // jog override with door open runs in low power
        i_sgm_switches.mode(1'b1, 1'b1);
        tick(4);
        `CHK(jog_latched, 1'b1)
        i_sgm_switches.door(1'b0, 1'b0);
        tick(4);
        `CHK({halt, low_power, high_power}, 3'h2)
        i_sgm_switches.mode(1'b0, 1'b0);
        tick(4);
        `CHK({jog_latched, motor_power, op_prohibit}, 3'h5)
        i_sgm_switches.release_pulse(); // jog clears, door still open
        tick(4);
        `CHK({jog_latched, door_latched, op_prohibit}, 3'h3)
        i_sgm_switches.door(1'b1, 1'b1);
        tick(4);
        i_sgm_switches.release_pulse();
        tick(4);
        start();
        // one stop contact opening cuts power and brakes
        i_sgm_switches.estop(1'b1, 1'b0);
        tick(4);
        `CHK({dyn_brake, motor_power, op_prohibit}, 3'h5)
        i_sgm_switches.estop(1'b1, 1'b1);
        tick(4);
        disc(0);
        disc(1);
        results();
    end
endmodule
